// ===== design/ssro_defs.vh
// Purpose: shared constants for the serial output / data-ready block
// Assumes: 50 MHz mclk, 16-bit configuration word, 12-bit result
// Notes:   definitions only, no logic
`ifndef SSRO_DEFS_VH
`define SSRO_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// configuration word layout
`define SSRO_CFG_W          16
`define SSRO_CFG_RESET      16'h058B
`define SSRO_START_BIT      15
`define SSRO_MUX_HI         14
`define SSRO_MUX_LO         12
`define SSRO_PGA_HI         11
`define SSRO_PGA_LO         9
`define SSRO_MODE_BIT       8
`define SSRO_DR_HI          7
`define SSRO_DR_LO          5
`define SSRO_TS_BIT         4
`define SSRO_PU_BIT         3
`define SSRO_WQ_HI          2
`define SSRO_WQ_LO          1
`define SSRO_WQ_WRITE       2'h1

////////////////////////////////////////////////////////////////////////////////
// input multiplexer selections
`define SSRO_MUX_A0_GND     3'h0
`define SSRO_MUX_A1_GND     3'h1
`define SSRO_MUX_A2_GND     3'h2
`define SSRO_MUX_A3_GND     3'h3
`define SSRO_MUX_A0_A3      3'h4
`define SSRO_MUX_A1_A3      3'h5
`define SSRO_MUX_A2_A3      3'h6
`define SSRO_MUX_A0_A1      3'h7

////////////////////////////////////////////////////////////////////////////////
// serial frame and timing
`define SSRO_RESULT_W       12
`define SSRO_FRAME_BITS     32
`define SSRO_LAST_RX_BIT    6'h0F
`define SSRO_BITCNT_MAX     6'h3F
`define SSRO_TIMEOUT_MS     28
`define SSRO_CLK_KHZ        50000
// 28 ms at 50 MHz, sized to the counter so no bits are dropped
`define SSRO_TIMEOUT_CYCLES 21'd1400000
`define SSRO_TO_W           21

`endif

// ===== design/ssro_edge.v
// Purpose: rise and fall detection of a level already synchronous to mclk
// Assumes: input sampled directly, no metastability hazard
// Notes:   pulses are combinational from the stored previous level
`timescale 1ns/100ps

module ssro_edge
(
	// clock and reset
	input  wire mclk,
	input  wire reset,
	input  wire rst_level,
	// level and edges
	input  wire level,
	output wire rise,
	output wire fall
);

reg prev_q;

always @(posedge mclk)
begin
	if (reset)
		prev_q <= rst_level;
	else
		prev_q <= level;
end

assign rise = level & ~prev_q;
assign fall = ~level & prev_q;

endmodule

// ===== design/ssro_timeout.v
// Purpose: counts cycles of a held condition and flags when the limit passes
// Assumes: run drops whenever the watched condition ends
// Notes:   limit is a parameter so simulation can shorten it
`timescale 1ns/100ps
`include "ssro_defs.vh"

module ssro_timeout
#(
	parameter [`SSRO_TO_W-1:0] LIMIT = `SSRO_TIMEOUT_CYCLES
)
(
	// clock and reset
	input  wire mclk,
	input  wire reset,
	// control
	input  wire run,
	output reg  expired_q
);

reg [`SSRO_TO_W-1:0] cnt_q;

always @(posedge mclk)
begin
	if (reset)
	begin
		cnt_q     <= {`SSRO_TO_W{1'b0}};
		expired_q <= 1'b0;
	end
	else if (!run)
	begin
		cnt_q     <= {`SSRO_TO_W{1'b0}};
		expired_q <= 1'b0;
	end
	else
	begin
		// one pulse only, on the cycle the hold count reaches the limit
		if (cnt_q != LIMIT)
			cnt_q <= cnt_q + {{(`SSRO_TO_W-1){1'b0}}, 1'b1};
		expired_q <= (cnt_q == LIMIT - {{(`SSRO_TO_W-1){1'b0}}, 1'b1});
	end
end

endmodule

// ===== design/ssro_top.v
// Purpose: shared-bus serial output with data-ready, readback protection and config
// Assumes: sclk, cs_n and din are synchronous to mclk and much slower than it
// Notes:   output pin is three signals; the testbench resolves the wire
//
// What this block does
// - answers only while its own chip select is low; bus lines are shared.
// - chip select high drives nothing but enables the weak pullup by default.
// - pullup enable cleared leaves the pin fully high impedance when deselected.
// - no ready indication appears on the pin while chip select is high.
// - on chip select falling the pin is driven at once, no clock needed.
// - waiting unread result drives the pin low and is ready to shift.
// - no new result drives the pin high and returns the last read result.
// - readout never corrupted; shifted word is a private copy.
// - result finishing mid-transfer waits for the next chip select assertion.
// - temperature sensor select at 1 converts the internal sensor.
// - multiplexer offers each analog input against ground, chosen by config.
// - multiplexer offers inputs 0, 1, 2 each against analog input 3.
// - mode 1: clock idles low, launch on rising, sample on falling.
// - config updates only when the write qualifier field equals 01.
// - clock low longer than 28 ms abandons the transfer.
`timescale 1ns/100ps
`include "ssro_defs.vh"

module ssro_top
#(
	parameter [`SSRO_TO_W-1:0] TIMEOUT_CYCLES = `SSRO_TIMEOUT_CYCLES
)
(
	// clock and reset
	input  wire                      mclk,
	input  wire                      reset,
	// serial bus
	input  wire                      sclk,
	input  wire                      cs_n,
	input  wire                      din,
	output wire                      serial_out_with_ready_o,
	output wire                      serial_out_with_ready_oe,
	output wire                      serial_out_with_ready_pu,
	// converter side
	input  wire [`SSRO_RESULT_W-1:0] conv_result,
	input  wire                      conv_done,
	// configuration outputs
	output wire                      temp_sensor_select,
	output wire [1:0]                mux_pos_sel,
	output wire [1:0]                mux_neg_sel,
	output wire                      mux_neg_gnd,
	output wire [2:0]                pga_sel,
	output wire                      single_shot_mode,
	output wire [2:0]                data_rate_sel,
	output wire                      start_request,
	// status
	output wire                      new_data_pending,
	output wire                      frame_timeout
);

////////////////////////////////////////////////////////////////////////////////
// states

localparam [3:0] ST_IDLE = 4'h1;
localparam [3:0] ST_WAIT = 4'h2;
localparam [3:0] ST_XFER = 4'h4;
localparam [3:0] ST_DEAD = 4'h8;

localparam [`SSRO_CFG_W-1:0] CFG_RST = `SSRO_CFG_RESET;

////////////////////////////////////////////////////////////////////////////////
// multiplexer decode: {neg is ground, positive input, negative input}

function [4:0] mux_decode;
	input [2:0] code;
	begin
		case (code)
			`SSRO_MUX_A0_GND: mux_decode = {1'b1, 2'h0, 2'h0};
			`SSRO_MUX_A1_GND: mux_decode = {1'b1, 2'h1, 2'h0};
			`SSRO_MUX_A2_GND: mux_decode = {1'b1, 2'h2, 2'h0};
			`SSRO_MUX_A3_GND: mux_decode = {1'b1, 2'h3, 2'h0};
			`SSRO_MUX_A0_A3:  mux_decode = {1'b0, 2'h0, 2'h3};
			`SSRO_MUX_A1_A3:  mux_decode = {1'b0, 2'h1, 2'h3};
			`SSRO_MUX_A2_A3:  mux_decode = {1'b0, 2'h2, 2'h3};
			default:          mux_decode = {1'b0, 2'h0, 2'h1};
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// registers

reg  [3:0]                      state_q;
reg  [`SSRO_CFG_W-1:0]          cfg_q;
reg  [`SSRO_RESULT_W-1:0]       hold_q;
reg  [`SSRO_RESULT_W-1:0]       last_q;
reg                             new_q;
reg                             frame_new_q;
reg  [`SSRO_FRAME_BITS-1:0]     tx_q;
reg  [`SSRO_CFG_W-2:0]          rx_q;
reg  [5:0]                      bitcnt_q;
reg                             pin_q;
reg                             oe_q;
reg                             pu_q;
reg  [4:0]                      mux_q;
reg                             start_q;
reg                             timeout_q;

wire                            sclk_rise;
wire                            sclk_fall;
wire                            cs_rise;
wire                            cs_fall;
wire                            to_expired;
wire                            read_take;
wire                            to_run;
wire [`SSRO_CFG_W-1:0]          rx_word;

////////////////////////////////////////////////////////////////////////////////
// edges and timeout

ssro_edge u_sclk_edge
(
	.mclk      (mclk),
	.reset     (reset),
	.rst_level (1'b0),
	.level     (sclk),
	.rise      (sclk_rise),
	.fall      (sclk_fall)
);

ssro_edge u_cs_edge
(
	.mclk      (mclk),
	.reset     (reset),
	.rst_level (1'b1),
	.level     (cs_n),
	.rise      (cs_rise),
	.fall      (cs_fall)
);

assign to_run = (state_q == ST_XFER) & ~sclk & ~cs_n;

ssro_timeout #(.LIMIT (TIMEOUT_CYCLES)) u_timeout
(
	.mclk      (mclk),
	.reset     (reset),
	.run       (to_run),
	.expired_q (to_expired)
);

assign read_take = (state_q == ST_WAIT) & ~cs_n & sclk_rise & frame_new_q;

assign rx_word = {rx_q, din};

////////////////////////////////////////////////////////////////////////////////
// result capture and new-data flag

always @(posedge mclk)
begin
	if (reset)
	begin
		hold_q <= {`SSRO_RESULT_W{1'b0}};
		last_q <= {`SSRO_RESULT_W{1'b0}};
		new_q  <= 1'b0;
	end
	else
	begin
		if (conv_done)
			hold_q <= conv_result;
		// set wins over the read so a fresh result is never dropped
		new_q <= conv_done | (new_q & ~read_take);
		if (read_take)
			last_q <= tx_q[`SSRO_FRAME_BITS-1 -: `SSRO_RESULT_W];
	end
end

////////////////////////////////////////////////////////////////////////////////
// frame state machine

always @(posedge mclk)
begin
	if (reset)
	begin
		state_q     <= ST_IDLE;
		cfg_q       <= `SSRO_CFG_RESET;
		frame_new_q <= 1'b0;
		tx_q        <= {`SSRO_FRAME_BITS{1'b0}};
		rx_q        <= {(`SSRO_CFG_W-1){1'b0}};
		bitcnt_q    <= 6'h00;
		pin_q       <= 1'b1;
		oe_q        <= 1'b0;
		pu_q        <= 1'b1;
		start_q     <= 1'b0;
		timeout_q   <= 1'b0;
	end
	else
	begin
		start_q   <= 1'b0;
		timeout_q <= 1'b0;
		if (cs_n)
		begin
			state_q <= ST_IDLE;
			oe_q    <= 1'b0;
			pu_q    <= cfg_q[`SSRO_PU_BIT];
			pin_q   <= 1'b1;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
				begin
					if (cs_fall)
					begin
						oe_q        <= 1'b1;
						pu_q        <= 1'b0;
						state_q     <= ST_WAIT;
						bitcnt_q    <= 6'h00;
						frame_new_q <= new_q;
						pin_q       <= ~new_q;
						tx_q        <= {(new_q ? hold_q : last_q), 4'h0, cfg_q};
					end
				end
				ST_WAIT:
				begin
					if (sclk_rise)
					begin
						pin_q   <= tx_q[`SSRO_FRAME_BITS-1];
						tx_q    <= {tx_q[`SSRO_FRAME_BITS-2:0], 1'b0};
						state_q <= ST_XFER;
					end
					else if (conv_done)
					begin
						// ready falls before any clock
						// a later result before the first clock replaces the older one, so the newest is read
						frame_new_q <= 1'b1;
						pin_q       <= 1'b0;
						tx_q        <= {conv_result, 4'h0, cfg_q};
					end
				end
				ST_XFER:
				begin
					// no reload here; new results wait
					if (to_expired)
					begin
						state_q   <= ST_DEAD;
						timeout_q <= 1'b1;
						pin_q     <= 1'b1;
					end
					else
					begin
						if (sclk_rise)
						begin
							pin_q <= tx_q[`SSRO_FRAME_BITS-1];
							tx_q  <= {tx_q[`SSRO_FRAME_BITS-2:0], 1'b0};
						end
						if (sclk_fall)
						begin
							rx_q <= rx_word[`SSRO_CFG_W-2:0];
							if (bitcnt_q != `SSRO_BITCNT_MAX)
								bitcnt_q <= bitcnt_q + 6'h01;
							if (bitcnt_q == `SSRO_LAST_RX_BIT &&
								rx_word[`SSRO_WQ_HI:`SSRO_WQ_LO] == `SSRO_WQ_WRITE)
							begin
								cfg_q   <= rx_word;
								start_q <= rx_word[`SSRO_START_BIT];
							end
						end
					end
				end
				ST_DEAD:
				begin
					// abandoned frame stays quiet until deselect
					pin_q <= 1'b1;
				end
				default:
				begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// configuration outputs

always @(posedge mclk)
begin
	if (reset)
		mux_q <= mux_decode(CFG_RST[`SSRO_MUX_HI:`SSRO_MUX_LO]);
	else
		// input choice; common point on ground for codes 0 to 3, on input 3 for codes 4 to 6
		mux_q <= mux_decode(cfg_q[`SSRO_MUX_HI:`SSRO_MUX_LO]);
end

assign serial_out_with_ready_o  = pin_q;
assign serial_out_with_ready_oe = oe_q;
assign serial_out_with_ready_pu = pu_q;
assign temp_sensor_select       = cfg_q[`SSRO_TS_BIT];
assign mux_neg_gnd              = mux_q[4];
assign mux_pos_sel              = mux_q[3:2];
assign mux_neg_sel              = mux_q[1:0];
assign pga_sel                  = cfg_q[`SSRO_PGA_HI:`SSRO_PGA_LO];
assign single_shot_mode         = cfg_q[`SSRO_MODE_BIT];
assign data_rate_sel            = cfg_q[`SSRO_DR_HI:`SSRO_DR_LO];
assign start_request            = start_q;
assign new_data_pending         = new_q;
assign frame_timeout            = timeout_q;

endmodule

// ===== tb/ssro_checker.sv
// Purpose: port assertions for ssro_top
// Assumes: one mclk domain, sync reset
// Notes:   bind at the foot
`timescale 1ns/100ps

module ssro_checker
(
	// clock and reset
	input wire       mclk,
	input wire       reset,
	// watched ports
	input wire       sclk,
	input wire       cs_n,
	input wire       conv_done,
	input wire       serial_out_with_ready_o,
	input wire       serial_out_with_ready_oe,
	input wire       serial_out_with_ready_pu,
	input wire       temp_sensor_select,
	input wire [1:0] mux_pos_sel,
	input wire       new_data_pending,
	input wire       frame_timeout
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	property p_idle; cs_n && $past(cs_n) |-> !serial_out_with_ready_oe; endproperty
	a_idle: assert property (p_idle) else $error("pin driven while deselected");
	property p_drive; $fell(cs_n) |=> serial_out_with_ready_oe; endproperty
	a_drive: assert property (p_drive) else $error("pin not driven after select");
	property p_rdy_lo; $fell(cs_n) && new_data_pending |=> !serial_out_with_ready_o; endproperty
	a_rdy_lo: assert property (p_rdy_lo) else $error("ready not low");
	property p_rdy_hi; $fell(cs_n) && !new_data_pending |=> serial_out_with_ready_o; endproperty
	a_rdy_hi: assert property (p_rdy_hi) else $error("ready not high");
	property p_no_pu; !cs_n ##1 !cs_n |-> !serial_out_with_ready_pu; endproperty
	a_no_pu: assert property (p_no_pu) else $error("pullup on while selected");
	property p_cfg_hold; cs_n && $past(cs_n, 3) |-> $stable(temp_sensor_select) && $stable(mux_pos_sel); endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config moved while idle");
	property p_to_cause; frame_timeout |-> !$past(cs_n) && !$past(sclk); endproperty
	a_to_cause: assert property (p_to_cause) else $error("timeout without low clock");
	property p_to_dead; frame_timeout |-> ##[1:2] (serial_out_with_ready_oe && serial_out_with_ready_o); endproperty
	a_to_dead: assert property (p_to_dead) else $error("pin not high after timeout");
	property p_new_clr; $fell(new_data_pending) |-> !cs_n && !$past(cs_n) && $past(sclk); endproperty
	a_new_clr: assert property (p_new_clr) else $error("new flag cleared without read");
	property p_new_set; $rose(new_data_pending) |-> $past(conv_done); endproperty
	a_new_set: assert property (p_new_set) else $error("new flag set without result");

	c_rdy_lo: cover property ($fell(cs_n) && new_data_pending);
	c_to: cover property (frame_timeout);
	c_mux: cover property ($changed(mux_pos_sel));
endmodule

bind ssro_top ssro_checker i_chk (.mclk, .reset, .sclk, .cs_n, .conv_done, .serial_out_with_ready_o,
	.serial_out_with_ready_oe, .serial_out_with_ready_pu, .temp_sensor_select, .mux_pos_sel,
	.new_data_pending, .frame_timeout);

// ===== tb/ssro_master.sv
// Purpose: serial bus master on the far side
// Assumes: bus driven at mclk falling edges
// Notes:   clock stands low outside frames
`timescale 1ns/100ps

module ssro_master
(
	// clock
	input  wire mclk,
	// bus lines
	input  wire pin,
	output reg  sclk,
	output reg  cs_n,
	output reg  din
);
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din  = 1'b0;
	end

	task frame(input [15:0] w, input integer n, input integer hp, input integer stall,
		output [31:0] r, output rdy);
		integer i;
		begin
			r = 32'h0;
			@(negedge mclk);
			cs_n = 1'b0;
			repeat (2) @(negedge mclk);
			rdy = pin;
			@(negedge mclk);
			for (i = 0; i < n; i = i + 1)
			begin
				sclk = 1'b1;
				din  = (i < 16) ? w[15 - i] : 1'b0;
				repeat (hp) @(negedge mclk);
				sclk = 1'b0;
				r    = {r[30:0], pin};
				repeat (hp) @(negedge mclk);
			end
			repeat (stall) @(negedge mclk);
			cs_n = 1'b1;
			din  = ~din;
		end
	endtask
endmodule

// ===== tb/ssro_top_tb.sv
// Purpose: self-checking bench for ssro_top
// Assumes: timeout shortened to 20 cycles
// Notes:   pin resolved from drive and pullup
`timescale 1ns/100ps

module ssro_top_tb;
	reg         mclk;
	reg         reset;
	reg  [11:0] conv_result;
	reg         conv_done;
	wire        sclk, cs_n, din, o, oe, pu, ts, gnd, mode, nd, to, st;
	wire [1:0]  pos, neg;
	wire [2:0]  pga, rate;
	wire        pin = oe ? o : (pu ? 1'b1 : 1'bz);
	integer     error_cnt, comparisons, to_cnt, st_cnt, k;
	reg  [31:0] r;
	reg         rdy;

	ssro_top #(.TIMEOUT_CYCLES(21'd20)) i_dut (.mclk(mclk), .reset(reset), .sclk(sclk), .cs_n(cs_n),
		.din(din), .serial_out_with_ready_o(o), .serial_out_with_ready_oe(oe),
		.serial_out_with_ready_pu(pu), .conv_result(conv_result), .conv_done(conv_done),
		.temp_sensor_select(ts), .mux_pos_sel(pos), .mux_neg_sel(neg), .mux_neg_gnd(gnd),
		.pga_sel(pga), .single_shot_mode(mode), .data_rate_sel(rate), .start_request(st),
		.new_data_pending(nd), .frame_timeout(to));
	ssro_master i_mst (.mclk(mclk), .pin(pin), .sclk(sclk), .cs_n(cs_n), .din(din));

	always #10 mclk = ~mclk;
	always @(posedge mclk) if (to) to_cnt = to_cnt + 1;
	always @(posedge mclk) if (st) st_cnt = st_cnt + 1;

	////////////////////////////////////////////////////////////////////////////////
	task chk(input [31:0] got, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp)
			begin
				error_cnt = error_cnt + 1;
				$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask

	task test_done;
		begin
			if (error_cnt == 0 && comparisons > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask

	function [15:0] cw(input [2:0] m, input t, input p, input [1:0] q);
		cw = {1'b0, m, 3'h4, 1'b0, 3'h3, t, p, q, 1'b1};
	endfunction

	task conv(input [11:0] v);
		begin
			@(negedge mclk);
			conv_result = v;
			conv_done   = 1'b1;
			@(negedge mclk);
			conv_done   = 1'b0;
			conv_result = ~v;
		end
	endtask

	task fr(input [15:0] w, input integer n, input integer hp, input integer stall);
		begin
			i_mst.frame(w, n, hp, stall, r, rdy);
			repeat (4) @(negedge mclk);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task t_ready;
		begin
			conv(12'hA5C);
			repeat (3) @(negedge mclk);
			chk(pin, 1'b1);
			fr(cw(3'h5, 1'b1, 1'b0, 2'h0), 32, 2, 0);
			chk(rdy, 1'b0);
			chk(r, {12'hA5C, 4'h0, 16'h058B});
			chk(nd, 1'b0);
			fr(16'h0, 32, 8, 0);
			chk(rdy, 1'b1);
			chk(r, {12'hA5C, 4'h0, 16'h058B});
		end
	endtask

	task t_mid;
		begin
			fork
				fr(16'h0, 32, 2, 0);
				begin
					repeat (20) @(negedge mclk);
					conv(12'h3C1);
				end
			join
			chk(r[31:20], 12'hA5C);
			fr(16'h0, 32, 2, 0);
			chk(rdy, 1'b0);
			chk(r[31:20], 12'h3C1);
		end
	endtask

	task t_cfg;
		begin
			for (k = 0; k < 7; k = k + 1)
			begin
				fr(cw(k[2:0], k[0], 1'b1, 2'h1), 16, 2, 0);
				chk({ts, pos, gnd, gnd ? 2'h0 : neg}, {k[0], k[1:0], ~k[2], k[2] ? 2'h3 : 2'h0});
				chk({pga, mode, rate}, {3'h4, 1'b0, 3'h3});
			end
			for (k = 0; k < 4; k = k + 1 + (k == 0))
			begin
				fr(cw(3'h1, 1'b1, 1'b0, k[1:0]) | 16'h8000, 16, 2, 0);
				chk({ts, pos, gnd, neg}, {1'b0, 2'h2, 1'b0, 2'h3});
			end
			fr(cw(3'h7, 1'b0, 1'b0, 2'h1), 16, 2, 0);
			chk(pin, 1'bz);
			chk({pos, gnd, neg}, {2'h0, 1'b0, 2'h1});
			fr(cw(3'h0, 1'b0, 1'b1, 2'h1) | 16'h8000, 16, 2, 0);
			chk(pin, 1'b1);
			chk(st_cnt, 1);
		end
	endtask

	task t_timeout;
		begin
			k = to_cnt;
			fr(16'h0, 2, 2, 40);
			chk(to_cnt - k, 1);
			fr(16'h0, 32, 2, 0);
			chk(to_cnt - k, 1);
			chk(rdy, 1'b1);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		mclk        = 1'b0;
		reset       = 1'b1;
		conv_result = 12'h000;
		conv_done   = 1'b0;
		error_cnt   = 0;
		comparisons = 0;
		to_cnt      = 0;
		st_cnt      = 0;
		repeat (20) @(negedge mclk);
		reset = 1'b0;
		@(negedge mclk);
		chk({oe, pu, pin, ts, pos, gnd, pga, mode, rate, nd}, {3'h3, 3'h0, 1'b1, 3'h2, 1'b1, 3'h4, 1'b0});
		t_ready;
		t_mid;
		t_cfg;
		t_timeout;
		test_done;
	end

	// hang guard
	initial
	begin
		repeat (90000) @(posedge mclk);
		error_cnt = error_cnt + 1;
		$display("[FAIL] %0t run timed out", $time);
		test_done;
	end
endmodule
